// ===== logic/mhp_pwm_top.sv
`timescale 1ns/1ps
module mhp_pwm_top
  import mhp_pkg::*;
#(
  parameter int NCH = CHANNEL_COUNT,
  parameter int TW = TIME_WIDTH,
  parameter bit REDUCED = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic setupStrobe,
  input wire logic [TW-1:0] cycleTimeUs,
  input wire logic [3:0] channelEntryCount,
  input wire logic [NCH*TW-1:0] highTimeListA,
  output logic [NCH-1:0] pwmOut,
  output logic [NCH-1:0] pwmOutEn,
  output logic [NCH-1:0] setupDone
);
  localparam logic [NCH-1:0] PIN_MASK = REDUCED ? NCH'(REDUCED_PIN_MASK) : NCH'(FULL_PIN_MASK);

  mhp_tick_if tick ();
  logic [TW-1:0] usCount;

  // configuration group
  logic [TW-1:0] period_reg;
  logic [TW-1:0] period_next;
  logic [TW-1:0] highTime_reg [NCH];
  logic [TW-1:0] highTime_next [NCH];
  logic [NCH-1:0] active_reg;
  logic [NCH-1:0] active_next;
  logic [NCH-1:0] oe_reg;
  logic [NCH-1:0] oe_next;

  // status group
  logic [NCH-1:0] done_reg;
  logic [NCH-1:0] done_next;

  // pin level group
  logic [NCH-1:0] out_reg;
  logic [NCH-1:0] out_next;

  // list entry i sits at bits [i*TW +: TW]
  function automatic logic [TW-1:0] entryValue(input int idx, input logic [NCH*TW-1:0] list);
    entryValue = list[idx*TW +: TW];
  endfunction

  // entries past the count or holding minus one are skipped
  function automatic logic entryUsed(input int idx, input logic [3:0] cnt, input logic [TW-1:0] ht);
    entryUsed = (4'(idx) < cnt) && (ht != HIGH_TIME_SKIP);
  endfunction

  // level of one pin for the current microsecond count
  function automatic logic levelFor(
    input logic act,
    input logic routed,
    input logic [TW-1:0] count,
    input logic [TW-1:0] ht,
    input logic restart
  );
    // a restart forces low so the cycle after each setup strobe starts clean; wraps do not
    levelFor = act && routed && (count < ht) && !restart;
  endfunction

  mhp_timebase #(.TW(TW)) timebase (
    .clk(clk),
    .reset_n(reset_n),
    .restart(setupStrobe),
    .periodUs(period_next),
    .tick(tick),
    .usCount(usCount)
  );

  // configuration: taken only on the strobe
  always_comb begin
    period_next = period_reg;
    active_next = active_reg;
    oe_next = oe_reg;
    for (int i = 0; i < NCH; i++) begin
      highTime_next[i] = highTime_reg[i];
    end
    if (setupStrobe) begin
      // one shared period; per-channel mismatch is not checked
      period_next = cycleTimeUs;
      for (int i = 0; i < NCH; i++) begin
        if (entryUsed(i, channelEntryCount, entryValue(i, highTimeListA))) begin
          highTime_next[i] = entryValue(i, highTimeListA);
          active_next[i] = 1'b1;
          // unrouted slots still count but never drive
          oe_next[i] = PIN_MASK[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      period_reg <= PERIOD_RESET;
      active_reg <= '0;
      oe_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        highTime_reg[i] <= '0;
      end
    end else begin
      period_reg <= period_next;
      active_reg <= active_next;
      oe_reg <= oe_next;
      for (int i = 0; i < NCH; i++) begin
        highTime_reg[i] <= highTime_next[i];
      end
    end
  end

  // status: one pulse per accepted entry
  always_comb begin
    done_next = '0;
    if (setupStrobe) begin
      for (int i = 0; i < NCH; i++) begin
        if (entryUsed(i, channelEntryCount, entryValue(i, highTimeListA))) begin
          done_next[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_reg <= '0;
    end else begin
      done_reg <= done_next;
    end
  end

  // pin levels: registered, so one cycle behind the count
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      out_next[i] = levelFor(active_next[i], PIN_MASK[i], usCount, highTime_reg[i], setupStrobe);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign pwmOut = out_reg;
  assign pwmOutEn = oe_reg;
  assign setupDone = done_reg;
endmodule // mhp_pwm_top

// ===== logic/mhp_pkg.sv
package mhp_pkg;
  localparam int CHANNEL_COUNT = 8;
  localparam int ROUTED_REDUCED = 6;
  localparam int TIME_WIDTH = 24;
  localparam int CLOCK_MHZ = 40;
  // one microsecond at 40 MHz
  localparam int US_TICK_CYCLES = CLOCK_MHZ;
  localparam logic [TIME_WIDTH-1:0] PERIOD_RESET = 24'h000000;
  localparam logic [TIME_WIDTH-1:0] HIGH_TIME_SKIP = 24'hffffff;
  // reduced build: slots 3 and 5 (channel3, channel5) have no pin
  localparam logic [CHANNEL_COUNT-1:0] REDUCED_PIN_MASK = 8'hd7;
  localparam logic [CHANNEL_COUNT-1:0] FULL_PIN_MASK = 8'hff;
endpackage

// ===== logic/mhp_tick_if.sv
`timescale 1ns/1ps
interface mhp_tick_if;
  logic usTick;
  logic cycleStart;
  modport source(output usTick, output cycleStart);
  modport sink(input usTick, input cycleStart);
endinterface

// ===== logic/mhp_timebase.sv
`timescale 1ns/1ps
module mhp_timebase
  import mhp_pkg::*;
#(
  parameter int TW = TIME_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic [TW-1:0] periodUs,
  mhp_tick_if.source tick,
  output logic [TW-1:0] usCount
);
  logic [6:0] divCount_reg, divCount_next;
  logic [TW-1:0] usCount_reg, usCount_next;
  logic usTick_reg, usTick_next;
  logic start_reg, start_next;

  always_comb begin
    divCount_next = divCount_reg;
    usCount_next = usCount_reg;
    usTick_next = 1'b0;
    start_next = 1'b0;
    if (restart) begin
      divCount_next = 7'h00;
      usCount_next = '0;
      start_next = 1'b1;
    end else if (divCount_reg == 7'(US_TICK_CYCLES - 1)) begin
      divCount_next = 7'h00;
      usTick_next = 1'b1;
      // wrap closes one modulation cycle
      if (usCount_reg + 1'b1 >= periodUs) begin
        usCount_next = '0;
        start_next = 1'b1;
      end else begin
        usCount_next = usCount_reg + 1'b1;
      end
    end else begin
      divCount_next = divCount_reg + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCount_reg <= 7'h00;
      usCount_reg <= '0;
      usTick_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      divCount_reg <= divCount_next;
      usCount_reg <= usCount_next;
      usTick_reg <= usTick_next;
      start_reg <= start_next;
    end
  end

  assign tick.usTick = usTick_reg;
  assign tick.cycleStart = start_reg;
  assign usCount = usCount_reg;
endmodule // mhp_timebase

// ===== bench/mhp_pin_load.sv
`timescale 1ns/1ps
module mhp_pin_load (
  input wire logic clk,
  input wire logic [7:0] pwmOut,
  input wire logic [7:0] pwmOutEn,
  output logic [7:0] pinLevel
);
  logic [7:0] floatReg = 8'h55;
  always @(posedge clk) floatReg <= ~floatReg;
  // undriven pin floats: never repeat the last level
  assign pinLevel = (pwmOut & pwmOutEn) | (floatReg & ~pwmOutEn);
endmodule // mhp_pin_load

// ===== bench/mhp_pwm_top_sva.sv
`timescale 1ns/1ps
module mhp_pwm_top_chk
  import mhp_pkg::*;
#(parameter int NCH = 8, parameter int TW = 24, parameter bit REDUCED = 1'b0) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic setupStrobe,
  input wire logic [TW-1:0] cycleTimeUs,
  input wire logic [3:0] channelEntryCount,
  input wire logic [NCH*TW-1:0] highTimeListA,
  input wire logic [NCH-1:0] pwmOut,
  input wire logic [NCH-1:0] pwmOutEn,
  input wire logic [NCH-1:0] setupDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [TW-1:0] h0 = highTimeListA[TW-1:0];
  sequence runS;
    setupStrobe && channelEntryCount != 4'h0 && h0 != HIGH_TIME_SKIP && h0 != 24'h000000 ##1 !setupStrobe;
  endsequence
  take_done_a: assert property (runS |-> setupDone[0] && pwmOutEn[0]) else $error("not taken");
  first_high_a: assert property (runS |=> pwmOut[0]) else $error("no high");
  skip_keep_a: assert property (setupStrobe && h0 == HIGH_TIME_SKIP |=> !setupDone[0]) else $error("skip taken");
  en_hold_a: assert property (pwmOutEn[0] |=> pwmOutEn[0]) else $error("enable lost");
  unrouted_a: assert property (!REDUCED || (pwmOutEn & ~REDUCED_PIN_MASK) == 8'h00) else $error("bad slot");
  start_low_a: assert property (setupDone[0] |-> !pwmOut[0]) else $error("start high");
  done_cause_a: assert property (setupDone[0] |-> $past(setupStrobe)) else $error("stray done");
endmodule // mhp_pwm_top_chk
bind mhp_pwm_top mhp_pwm_top_chk #(.NCH(NCH), .TW(TW), .REDUCED(REDUCED)) chk_u (.*);

// ===== bench/multi_channel_hw_pwm_tb.sv
`timescale 1ns/1ps
module multi_channel_hw_pwm_tb;
  import mhp_pkg::*;
  logic clk = 0, reset_n = 0, setupStrobe = 0;
  logic [3:0] channelEntryCount = 4'h8;
  logic [23:0] cycleUs = 24'h000003;
  logic [191:0] highTimeListA = '0;
  logic [7:0] pwmOut, pwmOutEn, setupDone, pinLevel, expEn = 8'h00;
  int expHigh[8], cnt[8], mismatches, cmp_count, cyc;
  int unsigned seed = 16;
  always #12.5 clk = ~clk;
  mhp_pwm_top #(.REDUCED(1'b1)) dut_u (.clk(clk), .reset_n(reset_n), .setupStrobe(setupStrobe),
    .cycleTimeUs(cycleUs), .channelEntryCount(channelEntryCount), .highTimeListA(highTimeListA),
    .pwmOut(pwmOut), .pwmOutEn(pwmOutEn), .setupDone(setupDone));
  mhp_pin_load load_u (.clk(clk), .pwmOut(pwmOut), .pwmOutEn(pwmOutEn), .pinLevel(pinLevel));
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % 6);
  endfunction
  // 240-cycle window spans whole periods of 2 or 3 us; high times above the period stay high
  function automatic int expCount(int h, int p);
    return (h < p ? h : p) * (6 / p) * US_TICK_CYCLES;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    int v;
    repeat (4) @(negedge clk);
    reset_n = 1;
    for (int r = 0; r < 3; r++) begin
      channelEntryCount = r == 1 ? 4'h3 : 4'h8;
      cycleUs = r == 1 ? 24'h000002 : 24'h000003;
      for (int i = 0; i < 8; i++) begin
        v = rnd();
        highTimeListA[i*24+:24] = v == 5 ? HIGH_TIME_SKIP : 24'(v);
        if (i < channelEntryCount && v != 5) begin
          expHigh[i] = v;
          expEn[i] = REDUCED_PIN_MASK[i];
          cnt[i] = 0;
        end
      end
      setupStrobe = 1;
      @(negedge clk);
      setupStrobe = 0;
      repeat (122) @(negedge clk);
      check(pwmOutEn, expEn);
      for (int i = 0; i < 8; i++) cnt[i] = 0;
      repeat (240) begin
        @(negedge clk);
        for (int i = 0; i < 8; i++) cnt[i] += pinLevel[i];
      end
      for (int i = 0; i < 8; i++) if (expEn[i]) check(cnt[i], expCount(expHigh[i], int'(cycleUs)));
    end
    reset_n = 0;
    @(negedge clk);
    check(pwmOutEn, 8'h00);
    end_sim();
  end
endmodule // multi_channel_hw_pwm_tb
